/* File: rtl/cbs_balance_ctrl.sv */
// cell balance control, scan sequencing and readout behind an axi4-lite slave
`timescale 1ns/100ps
module cbs_balance_ctrl #(
	parameter int MS_CYC   = cbs_pkg::MS_CYC_DEF,
	parameter int SUSP_CYC = cbs_pkg::SUSP_CYC_DEF
) (
	// clock and reset
	input  wire logic                          clk,
	input  wire logic                          nrst,
	// axi4-lite write channels
	input  wire logic [cbs_pkg::ADDR_W-1:0]    awaddr,
	input  wire logic                          awvalid,
	output logic                               awready,
	input  wire logic [cbs_pkg::DATA_W-1:0]    wdata,
	input  wire logic [3:0]                    wstrb,
	input  wire logic                          wvalid,
	output logic                               wready,
	output logic [1:0]                         bresp,
	output logic                               bvalid,
	input  wire logic                          bready,
	// axi4-lite read channels
	input  wire logic [cbs_pkg::ADDR_W-1:0]    araddr,
	input  wire logic                          arvalid,
	output logic                               arready,
	output logic [cbs_pkg::DATA_W-1:0]         rdata,
	output logic [1:0]                         rresp,
	output logic                               rvalid,
	input  wire logic                          rready,
	// converter
	output logic                               convStart,
	output logic [cbs_pkg::IDX_W-1:0]          convCell,
	input  wire logic                          convDone,
	input  wire logic [cbs_pkg::ADC_W:0]       convData,
	// balance drives and switch select
	output logic [cbs_pkg::N_CELLS-1:0]        balanceDriveOutput,
	output logic                               internalBalanceSelect,
	// per-input fault detection enables
	output logic [cbs_pkg::N_CELLS:0]          cellFaultCheckEn
);
	import cbs_pkg::*;

	logic [DATA_W-1:0] setup_q;
	logic [15:0]       balTime_q, autoDelta_q, autoCycle_q;
	logic [DIS_W-1:0]  cellDis_q;
	logic              awHeld_q, wHeld_q, bvalid_q, rvalid_q;
	logic [ADDR_W-1:0] awAddr_q;
	logic [DATA_W-1:0] wData_q, rdata_q;
	logic [3:0]        wStrb_q;
	logic [1:0]        bresp_q, rresp_q;
	logic              inhibit_q, susp_q, timedRun_q, autoRun_q, phase_q, convPend_q;
	logic [15:0]       timeLeft_q, autoMs_q;
	logic [7:0]        gapMs_q;
	cbs_scan_e         scan_q;
	logic [IDX_W-1:0]  scanIdx_q, rdPtr_q;
	logic [N_CELLS-1:0] drive_q;
	logic [ADC_W-1:0]  cellMem_q [N_CELLS];
	logic [15:0]       charge_q [N_CELLS];

	// merge a write under its byte strobes
	function automatic logic [DATA_W-1:0] applyStrb(input logic [DATA_W-1:0] old,
			input logic [DATA_W-1:0] nw, input logic [3:0] strb);
		logic [DATA_W-1:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return r;
	endfunction

	// first enabled cell at or after a start index
	function automatic logic [IDX_W-1:0] nextCell(input logic [N_CELLS-1:0] en,
			input logic [IDX_W-1:0] from);
		logic [IDX_W-1:0] r;
		r = IDX_NONE;
		for (int i = N_CELLS - 1; i >= 0; i--) begin
			if (en[i] && IDX_W'(i) >= from) begin
				r = IDX_W'(i);
			end
		end
		return r;
	endfunction

	// decoded fields
	cbs_mode_e          mode;
	logic [N_CELLS-1:0] cellBits, cellEn;
	logic               suspBit, contBit;
	assign mode     = cbs_mode_e'(setup_q[SET_MODE_LO +: 2]);
	assign cellBits = setup_q[SET_CELL_LO +: N_CELLS];
	assign suspBit  = setup_q[SET_SUSPEND];
	assign contBit  = setup_q[SET_CONT];
	assign cellEn   = ~cellDis_q[N_CELLS:1];
	assign internalBalanceSelect = setup_q[SET_INTERNAL_BALANCE_SELECT];
	assign cellFaultCheckEn = ~cellDis_q[N_CELLS:0];

	// write path: address and data taken in either order
	logic doWrite, doRead;
	assign awready = !awHeld_q && !bvalid_q;
	assign wready  = !wHeld_q && !bvalid_q;
	assign doWrite = awHeld_q && wHeld_q && !bvalid_q;
	assign arready = !rvalid_q;
	assign doRead  = arvalid && arready;
	assign bvalid  = bvalid_q;
	assign bresp   = bresp_q;
	assign rvalid  = rvalid_q;
	assign rdata   = rdata_q;
	assign rresp   = rresp_q;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			awHeld_q <= 1'b0;
			wHeld_q  <= 1'b0;
			awAddr_q <= '0;
			wData_q  <= '0;
			wStrb_q  <= '0;
		end else begin
			if (awvalid && awready) begin
				awHeld_q <= 1'b1;
				awAddr_q <= awaddr;
			end else if (doWrite) begin
				awHeld_q <= 1'b0;
			end
			if (wvalid && wready) begin
				wHeld_q <= 1'b1;
				wData_q <= wdata;
				wStrb_q <= wstrb;
			end else if (doWrite) begin
				wHeld_q <= 1'b0;
			end
		end
	end

	logic wrMapped;
	always_comb begin
		case (awAddr_q)
			OFF_BAL_SETUP, OFF_BAL_TIME, OFF_AUTO_DELTA, OFF_AUTO_CYCLE,
			OFF_COMMAND, OFF_CELL_DATA, OFF_CELL_DIS: wrMapped = 1'b1;
			default: wrMapped = 1'b0;
		endcase
	end

	// write response, slverr for holes in the map
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			bvalid_q <= 1'b0;
			bresp_q  <= RESP_OKAY;
		end else if (doWrite) begin
			bvalid_q <= 1'b1;
			bresp_q  <= wrMapped ? RESP_OKAY : RESP_SLVERR;
		end else if (bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// software registers; reset leaves every mode off
	logic [DATA_W-1:0] wMerged;
	logic [DATA_W-1:0] wTime, wDelta, wCycle, wDis;
	assign wMerged = applyStrb('0, wData_q, wStrb_q);
	// strobe-merged values of the 16-bit registers; a zero time is stored as written
	assign wTime   = applyStrb({16'h0, balTime_q}, wData_q, wStrb_q);
	assign wDelta  = applyStrb({16'h0, autoDelta_q}, wData_q, wStrb_q);
	assign wCycle  = applyStrb({16'h0, autoCycle_q}, wData_q, wStrb_q);
	assign wDis    = applyStrb({16'h0, cellDis_q}, wData_q, wStrb_q);
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			setup_q     <= '0;
			balTime_q   <= '0;
			autoDelta_q <= '0;
			autoCycle_q <= '0;
			cellDis_q   <= '0;
		end else if (doWrite) begin
			case (awAddr_q)
				OFF_BAL_SETUP:  setup_q <= applyStrb(setup_q, wData_q, wStrb_q) & SET_MASK;
				OFF_BAL_TIME:   balTime_q   <= wTime[15:0];
				OFF_AUTO_DELTA: autoDelta_q <= wDelta[15:0];
				OFF_AUTO_CYCLE: autoCycle_q <= wCycle[15:0];
				// inputs 0, 1 and bit 15 never stick
				OFF_CELL_DIS:   cellDis_q   <= wDis[15:0] & DIS_WMASK;
				default: ;
			endcase
		end
	end

	// command pulses
	logic cmdWr, cmdStart, cmdInhibit, cmdEnable, cmdScan, cmdStop;
	assign cmdWr      = doWrite && awAddr_q == OFF_COMMAND;
	assign cmdStart   = cmdWr && wMerged[CMD_START];
	assign cmdInhibit = cmdWr && wMerged[CMD_INHIBIT];
	assign cmdEnable  = cmdWr && wMerged[CMD_ENABLE];
	assign cmdScan    = cmdWr && wMerged[CMD_SCAN];
	assign cmdStop    = cmdWr && wMerged[CMD_STOP];

	// millisecond base restarts on start so durations are whole
	logic msTick, suspTick, suspEnter;
	cbs_tick #(.CYC(MS_CYC)) uMs (
		.clk     (clk),
		.nrst    (nrst),
		.restart (cmdStart),
		.tick    (msTick)
	);
	cbs_tick #(.CYC(SUSP_CYC)) uSusp (
		.clk     (clk),
		.nrst    (nrst),
		.restart (suspEnter),
		.tick    (suspTick)
	);

	// inhibit wins over enable when both arrive together
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			inhibit_q <= 1'b0;
		end else if (cmdInhibit) begin
			inhibit_q <= 1'b1;
		end else if (cmdEnable) begin
			inhibit_q <= 1'b0;
		end
	end

	// timed run
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			timedRun_q <= 1'b0;
			timeLeft_q <= '0;
		end else if (cmdStop || mode != MODE_TIMED) begin
			timedRun_q <= 1'b0;
		end else if (cmdStart) begin
			timedRun_q <= balTime_q != 16'h0;
			timeLeft_q <= balTime_q;
		end else if (timedRun_q && msTick) begin
			timeLeft_q <= timeLeft_q - 1'b1;
			if (timeLeft_q == 16'h1) begin
				timedRun_q <= 1'b0;
			end
		end
	end

	// auto run: alternate odd and even cells so neighbours never drain together
	logic [N_CELLS-1:0] reached, autoMask;
	logic               autoDone;
	assign autoMask = (phase_q ? ~PHASE0_MASK : PHASE0_MASK) & ~reached;
	assign autoDone = &(reached | ~(cellBits & cellEn));
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			autoRun_q <= 1'b0;
			phase_q   <= 1'b0;
			autoMs_q  <= '0;
		end else if (cmdStop || mode != MODE_AUTO) begin
			autoRun_q <= 1'b0;
		end else if (cmdStart) begin
			autoRun_q <= 1'b1;
			phase_q   <= 1'b0;
			autoMs_q  <= '0;
		end else if (autoRun_q) begin
			if (autoDone) begin
				autoRun_q <= 1'b0;
			end else if (msTick) begin
				if (autoMs_q + 1'b1 >= autoCycle_q) begin
					autoMs_q <= '0;
					phase_q  <= !phase_q;
				end else begin
					autoMs_q <= autoMs_q + 1'b1;
				end
			end
		end
	end

	// removed charge per cell in drive-milliseconds
	for (genvar i = 0; i < N_CELLS; i++) begin : gCharge
		assign reached[i] = charge_q[i] >= autoDelta_q;
		always_ff @(posedge clk or negedge nrst) begin
			if (!nrst) begin
				charge_q[i] <= '0;
			end else if (cmdStart && mode == MODE_AUTO) begin
				charge_q[i] <= '0;
			end else if (autoRun_q && msTick && drive_q[i]) begin
				charge_q[i] <= charge_q[i] + 1'b1;
			end
		end
	end

	// scan sequencer with optional quiet period ahead of conversions
	logic suspApply, scanReq, scanEnd;
	assign suspApply = suspBit && mode != MODE_OFF && (contBit || mode == MODE_AUTO);
	assign scanReq   = cmdScan || contBit;
	assign scanEnd   = scan_q == SC_CONV && convDone && convPend_q && scanIdx_q == IDX_LAST;
	assign suspEnter = scan_q == SC_IDLE && scanReq && suspApply;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			scan_q     <= SC_IDLE;
			susp_q     <= 1'b0;
			scanIdx_q  <= '0;
			convPend_q <= 1'b0;
			gapMs_q    <= '0;
		end else begin
			case (scan_q)
				SC_IDLE: begin
					scanIdx_q <= '0;
					if (suspEnter) begin
						scan_q <= SC_SUSP;
						susp_q <= 1'b1;
					end else if (scanReq) begin
						scan_q <= SC_CONV;
					end
				end
				SC_SUSP: if (suspTick) begin
					scan_q <= SC_CONV;
				end
				SC_CONV: begin
					if (!convPend_q) begin
						convPend_q <= 1'b1;
					end else if (convDone) begin
						convPend_q <= 1'b0;
						scanIdx_q  <= scanIdx_q + 1'b1;
						if (scanIdx_q == IDX_LAST) begin
							susp_q  <= 1'b0;
							gapMs_q <= '0;
							scan_q  <= contBit ? SC_GAP : SC_IDLE;
						end
					end
				end
				SC_GAP: begin
					if (!contBit || gapMs_q == 8'(SCAN_GAP_MS)) begin
						scan_q <= SC_IDLE;
					end else if (msTick) begin
						gapMs_q <= gapMs_q + 1'b1;
					end
				end
				default: scan_q <= SC_IDLE;
			endcase
		end
	end
	assign convStart = scan_q == SC_CONV && !convPend_q;
	assign convCell  = scanIdx_q;

	// results saturate instead of wrapping
	logic [ADC_W-1:0] sample;
	assign sample = convData[ADC_W] ? FULL_SCALE : convData[ADC_W-1:0];
	always_ff @(posedge clk) begin
		if (scan_q == SC_CONV && convPend_q && convDone) begin
			cellMem_q[scanIdx_q] <= sample;
		end
	end

	// drive select, then gating by inhibit, quiet period and disables
	logic [N_CELLS-1:0] modeDrive, driveD;
	always_comb begin
		case (mode)
			MODE_MANUAL: modeDrive = cellBits;
			MODE_TIMED:  modeDrive = timedRun_q ? cellBits : '0;
			MODE_AUTO:   modeDrive = autoRun_q ? (cellBits & autoMask) : '0;
			default:     modeDrive = '0;
		endcase
		// quiet period starts with the entry edge so it spans the full suspend count
		driveD = (inhibit_q || susp_q || suspEnter) ? '0 : (modeDrive & cellEn);
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			drive_q <= '0;
		end else begin
			drive_q <= driveD;
		end
	end
	assign balanceDriveOutput = drive_q;

	// read side; a cell data read hands out the next enabled cell only
	logic [IDX_W-1:0] rdIdx;
	assign rdIdx = nextCell(cellEn, rdPtr_q);
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rvalid_q <= 1'b0;
			rdata_q  <= '0;
			rresp_q  <= RESP_OKAY;
			rdPtr_q  <= '0;
		end else begin
			if (scanEnd || (doWrite && awAddr_q == OFF_CELL_DATA)) begin
				rdPtr_q <= '0;
			end
			if (doRead) begin
				rvalid_q <= 1'b1;
				rresp_q  <= RESP_OKAY;
				rdata_q  <= '0;
				case (araddr)
					OFF_BAL_SETUP:  rdata_q <= setup_q;
					OFF_BAL_TIME:   rdata_q <= {16'h0, balTime_q};
					OFF_AUTO_DELTA: rdata_q <= {16'h0, autoDelta_q};
					OFF_AUTO_CYCLE: rdata_q <= {16'h0, autoCycle_q};
					OFF_COMMAND:    rdata_q <= '0;
					OFF_STATUS:     rdata_q <= {16'h0, timeLeft_q[7:0], autoDone, phase_q,
							autoRun_q, timedRun_q, susp_q, inhibit_q, scan_q};
					OFF_CELL_DIS:   rdata_q <= {16'h0, cellDis_q};
					OFF_CELL_DATA: if (rdIdx != IDX_NONE) begin
						rdata_q[RD_VALID] <= 1'b1;
						rdata_q[RD_IDX_LO +: IDX_W] <= rdIdx + 1'b1;
						rdata_q[ADC_W-1:0] <= cellMem_q[rdIdx];
						rdPtr_q <= rdIdx + 1'b1;
					end
					default: rresp_q <= RESP_SLVERR;
				endcase
			end else if (rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	// checks
	chk_manual_drive: assert property (@(posedge clk) disable iff (!nrst)
		(mode == MODE_MANUAL && !inhibit_q && !susp_q && !suspEnter)
		|=> balanceDriveOutput == $past(cellBits & cellEn))
		else $error("manual drive does not follow cell bits");
	chk_timed_stop: assert property (@(posedge clk) disable iff (!nrst)
		$fell(timedRun_q) |=> balanceDriveOutput == '0)
		else $error("drives still on after timer expiry");
	chk_auto_alternate: assert property (@(posedge clk) disable iff (!nrst)
		$past(mode == MODE_AUTO) |-> (balanceDriveOutput & (balanceDriveOutput >> 1)) == '0)
		else $error("adjacent cells drained together");
	chk_quiet_before: assert property (@(posedge clk) disable iff (!nrst)
		scan_q == SC_SUSP ##1 scan_q == SC_CONV |-> balanceDriveOutput == '0)
		else $error("drive on at start of conversion");
	chk_auto_suspend: assert property (@(posedge clk) disable iff (!nrst)
		(scan_q == SC_IDLE && cmdScan && suspBit && mode == MODE_AUTO)
		|=> scan_q == SC_SUSP ##1 balanceDriveOutput == '0)
		else $error("auto mode did not suspend ahead of scan");
	chk_resume_after: assert property (@(posedge clk) disable iff (!nrst)
		scanEnd |=> !susp_q)
		else $error("suspension kept after scan end");
	chk_inhibit_off: assert property (@(posedge clk) disable iff (!nrst)
		cmdInhibit |=> ##1 balanceDriveOutput == '0)
		else $error("drive on after inhibit");
	chk_saturate: assert property (@(posedge clk) disable iff (!nrst)
		(scan_q == SC_CONV && convPend_q && convDone && convData[ADC_W])
		|=> cellMem_q[$past(scanIdx_q)] == FULL_SCALE)
		else $error("over-range reading not saturated");
	chk_disabled_idle: assert property (@(posedge clk) disable iff (!nrst)
		##1 (balanceDriveOutput & $past(~cellEn)) == '0)
		else $error("disabled cell balanced");
	chk_fixed_inputs: assert property (@(posedge clk) disable iff (!nrst)
		(cellDis_q & ~DIS_WMASK) == '0)
		else $error("input 0, 1 or bit 15 disabled");
	chk_skip_disabled: assert property (@(posedge clk) disable iff (!nrst)
		(doRead && araddr == OFF_CELL_DATA && rdIdx != IDX_NONE) |-> cellEn[rdIdx])
		else $error("readout of a disabled cell");
endmodule

/* File: rtl/cbs_pkg.sv */
// constants, register map and types for the cell balance and scan controller
// Function
// - manual mode: each drive follows its cell bit
// - timed mode: all drives off when timer expires
// - auto mode: sequenced cycles until charge removed
// - suspend bit: off 10ms before continuous scans
// - auto mode with suspend bit: off 10ms
// - balancing resumes when the scan finishes
// - inhibit command halts, enable command resumes
// - over-range reading saturates at full scale
// - disable bit: no faults, no balancing there
// - disable register 16 bits, inputs 2-14 only
// - readout skips disabled cells entirely
// - setup bit 8 selects internal switches
package cbs_pkg;
	localparam int N_CELLS  = 14;
	localparam int IDX_W    = 4;
	localparam int DIS_W    = 16;
	localparam int ADC_W    = 14;
	localparam int ADDR_W   = 12;
	localparam int DATA_W   = 32;
	// timing: figures in ns, counts derived from the clock period
	localparam int CLK_NS       = 4;
	localparam int MS_NS        = 1000000;
	localparam int SUSPEND_NS   = 10000000;
	localparam int MS_CYC_DEF   = (MS_NS + CLK_NS - 1) / CLK_NS;
	localparam int SUSP_CYC_DEF = (SUSPEND_NS + CLK_NS - 1) / CLK_NS;
	localparam int SCAN_GAP_MS  = 100;
	// register byte offsets
	localparam logic [ADDR_W-1:0] OFF_BAL_SETUP  = 12'h000;
	localparam logic [ADDR_W-1:0] OFF_BAL_TIME   = 12'h004;
	localparam logic [ADDR_W-1:0] OFF_AUTO_DELTA = 12'h008;
	localparam logic [ADDR_W-1:0] OFF_AUTO_CYCLE = 12'h00c;
	localparam logic [ADDR_W-1:0] OFF_COMMAND    = 12'h010;
	localparam logic [ADDR_W-1:0] OFF_STATUS     = 12'h014;
	localparam logic [ADDR_W-1:0] OFF_CELL_DATA  = 12'h018;
	localparam logic [ADDR_W-1:0] OFF_CELL_DIS   = 12'h040;
	// balance setup fields
	localparam int SET_MODE_LO = 0;
	localparam int SET_SUSPEND = 4;
	localparam int SET_CONT    = 5;
	localparam int SET_INTERNAL_BALANCE_SELECT    = 8;
	localparam int SET_CELL_LO = 16;
	localparam logic [DATA_W-1:0] SET_MASK  = 32'h3fff_0133;
	localparam logic [DIS_W-1:0]  DIS_WMASK = 16'h7ffc;
	// command bits
	localparam int CMD_START   = 0;
	localparam int CMD_INHIBIT = 1;
	localparam int CMD_ENABLE  = 2;
	localparam int CMD_SCAN    = 3;
	localparam int CMD_STOP    = 4;
	// cell data word
	localparam int RD_IDX_LO = 16;
	localparam int RD_VALID  = 31;
	localparam logic [ADC_W-1:0]   FULL_SCALE = 14'h3fff;
	localparam logic [IDX_W-1:0]   IDX_NONE   = 4'hf;
	localparam logic [IDX_W-1:0]   IDX_LAST   = 4'hd;
	localparam logic [N_CELLS-1:0] PHASE0_MASK = 14'h1555;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		MODE_OFF    = 2'h0,
		MODE_MANUAL = 2'h1,
		MODE_TIMED  = 2'h2,
		MODE_AUTO   = 2'h3
	} cbs_mode_e;

	// gray order along idle -> suspend -> convert -> gap
	typedef enum logic [1:0] {
		SC_IDLE = 2'b00,
		SC_SUSP = 2'b01,
		SC_CONV = 2'b11,
		SC_GAP  = 2'b10
	} cbs_scan_e;
endpackage

/* File: rtl/cbs_tick.sv */
// restartable divider giving a one-cycle enable every CYC clocks
`timescale 1ns/100ps
module cbs_tick #(
	parameter int CYC = 250000
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic nrst,
	// control and output
	input  wire logic restart,
	output logic      tick
);
	localparam int W = $clog2(CYC + 1);
	localparam logic [W-1:0] LAST = W'(CYC - 1);

	logic [W-1:0] cnt_q;

	// restart realigns the period so a waited time is exact
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_q <= '0;
		end else if (restart || cnt_q == LAST) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

	assign tick = !restart && (cnt_q == LAST);
endmodule

/* File: tb/cbs_conv_model.sv */
// behavioural converter that answers each conversion request of the controller
`timescale 1ns/100ps
module cbs_conv_model (
	// clock and reset
	input  wire logic                      clk,
	input  wire logic                      nrst,
	// request and answer
	input  wire logic                      convStart,
	input  wire logic [cbs_pkg::IDX_W-1:0] convCell,
	output logic                           convDone,
	output logic [cbs_pkg::ADC_W:0]        convData
);
	import cbs_pkg::*;

	logic [1:0]       cnt_q;
	logic [IDX_W-1:0] cell_q;

	// answer three cycles after the request; data toggles outside the answer
	// so a controller that samples at the wrong time never sees a stale match
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_q <= 2'h0;
			cell_q <= 4'h0;
			convDone <= 1'b0;
			convData <= 15'h0000;
		end else begin
			convDone <= 1'b0;
			convData <= ~convData;
			if (convStart) begin
				cell_q <= convCell;
				cnt_q <= 2'h2;
			end else if (cnt_q != 2'h0) begin
				cnt_q <= cnt_q - 2'h1;
			end
			if (cnt_q == 2'h1) begin
				convDone <= 1'b1;
				// cell 3 reads above the input range
				convData <= (cell_q == 4'h2) ? 15'h4000 : {11'h000, cell_q};
			end
		end
	end
endmodule

/* File: tb/tb_cbs_balance_ctrl.sv */
// self-checking bench for the cell balance and scan controller
`timescale 1ns/100ps
module tb_cbs_balance_ctrl;
	import cbs_pkg::*;

	logic               clk;
	logic               nrst;
	logic [ADDR_W-1:0]  awaddr;
	logic [ADDR_W-1:0]  araddr;
	logic               awvalid, awready, wvalid, wready, bvalid, bready;
	logic               arvalid, arready, rvalid, rready;
	logic [DATA_W-1:0]  wdata, rdata, rv;
	logic [3:0]         wstrb;
	logic [1:0]         bresp, rresp, rr, br;
	logic               convStart, convDone, internal_balance_select, both;
	logic [IDX_W-1:0]   convCell;
	logic [ADC_W:0]     convData;
	logic [N_CELLS-1:0] drv, seen;
	logic [N_CELLS:0]   faultEn;
	int                 miscompares, testsRun;

	// short ms and suspend counts keep the run brief
	cbs_balance_ctrl #(.MS_CYC(10), .SUSP_CYC(20)) u_dut (
		.clk(clk), .nrst(nrst),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.convStart(convStart), .convCell(convCell), .convDone(convDone),
		.convData(convData), .balanceDriveOutput(drv),
		.internalBalanceSelect(internal_balance_select), .cellFaultCheckEn(faultEn)
	);

	cbs_conv_model u_conv (
		.clk(clk), .nrst(nrst), .convStart(convStart), .convCell(convCell),
		.convDone(convDone), .convData(convData)
	);

	// 250 MHz clock
	always #2 clk = ~clk;

	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		testsRun++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// address and data offered together, each dropped once taken
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		logic aw;
		logic w;
		aw = 1'b1;
		w = 1'b1;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (aw || w) begin
			@(posedge clk);
			if (aw && awready) begin
				aw = 1'b0;
				awvalid <= 1'b0;
			end
			if (w && wready) begin
				w = 1'b0;
				wvalid <= 1'b0;
			end
		end
		do @(posedge clk); while (bvalid !== 1'b1);
		br = bresp;
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clk); while (rvalid !== 1'b1);
		rv = rdata;
		rr = rresp;
	endtask

	task automatic cmd(input int b);
		wr(OFF_COMMAND, 32'h1 << b);
	endtask

	task automatic waitConv;
		do @(posedge clk); while (convStart !== 1'b1);
	endtask

	task automatic summarize;
		$display("comparisons %0d mismatches %0d", testsRun, miscompares);
		if (miscompares == 0 && testsRun > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		nrst = 1'b0;
		awaddr = 12'h000;
		araddr = 12'h000;
		wdata = 32'h0;
		wstrb = 4'hf;
		awvalid = 1'b0;
		wvalid = 1'b0;
		arvalid = 1'b0;
		bready = 1'b1;
		rready = 1'b1;
		miscompares = 0;
		testsRun = 0;
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		// reset state and the disable register
		chk("drive rst", 32'(drv), 32'h0);
		chk("internal_balance_select rst", 32'(internal_balance_select), 32'h0);
		chk("fault en rst", 32'(faultEn), 32'h7fff);
		rd(OFF_CELL_DIS);
		chk("disable rst", rv, 32'h0);
		wr(OFF_CELL_DIS, 32'hffff);
		chk("wr resp", 32'(br), 32'(RESP_OKAY));
		rd(OFF_CELL_DIS);
		chk("disable wr", rv, 32'h7ffc);
		chk("fault en", 32'(faultEn), 32'h0003);
		// manual mode, internal switches, every cell requested
		wr(OFF_BAL_SETUP, 32'h3fff_0101);
		@(posedge clk);
		chk("drive masked", 32'(drv), 32'h0001);
		chk("internal_balance_select set", 32'(internal_balance_select), 32'h1);
		wr(OFF_CELL_DIS, 32'h0);
		@(posedge clk);
		chk("drive manual", 32'(drv), 32'h3fff);
		cmd(CMD_INHIBIT);
		@(posedge clk);
		chk("drive inhibit", 32'(drv), 32'h0);
		cmd(CMD_ENABLE);
		@(posedge clk);
		chk("drive enable", 32'(drv), 32'h3fff);
		rd(12'h100);
		chk("unmapped resp", 32'(rr), 32'(RESP_SLVERR));
		chk("unmapped data", rv, 32'h0);
		wr(12'h100, 32'h0);
		chk("unmapped wr resp", 32'(br), 32'(RESP_SLVERR));
		// timed run of 3 ms over cells 1 and 3
		wr(OFF_BAL_TIME, 32'h3);
		wr(OFF_BAL_SETUP, 32'h0005_0002);
		cmd(CMD_START);
		repeat (20) @(posedge clk);
		chk("timed on", 32'(drv), 32'h0005);
		repeat (20) @(posedge clk);
		chk("timed off", 32'(drv), 32'h0);
		cmd(CMD_START);
		@(posedge clk);
		chk("timed restart", 32'(drv), 32'h0005);
		cmd(CMD_STOP);
		@(posedge clk);
		chk("timed stop", 32'(drv), 32'h0);
		// continuous scan with suspend; cell 5 left out, cell 3 over range
		wr(OFF_CELL_DIS, 32'h0020);
		wr(OFF_BAL_SETUP, 32'h00ff_0031);
		waitConv;
		chk("suspend cont", 32'(drv), 32'h0);
		do rd(OFF_STATUS); while (rv[1:0] !== 2'b10);
		@(posedge clk);
		chk("resume", 32'(drv), 32'h00ef);
		wr(OFF_BAL_SETUP, 32'h00ff_0001);
		for (int c = 1; c <= 14; c++) begin
			if (c != 5) begin
				rd(OFF_CELL_DATA);
				chk("cell data", rv, {1'b1, 11'h0, 4'(c), 2'h0,
					(c == 3) ? 14'h3fff : 14'(c - 1)});
			end
		end
		rd(OFF_CELL_DATA);
		chk("data end", 32'(rv[RD_VALID]), 32'h0);
		// auto run: 2 drive-ms per cell, 1 ms half cycles, one suspended scan
		wr(OFF_AUTO_DELTA, 32'h2);
		wr(OFF_AUTO_CYCLE, 32'h1);
		wr(OFF_BAL_SETUP, 32'h0003_0013);
		cmd(CMD_START);
		cmd(CMD_SCAN);
		waitConv;
		chk("suspend auto", 32'(drv), 32'h0);
		seen = 14'h0;
		both = 1'b0;
		repeat (600) begin
			@(posedge clk);
			seen = seen | drv;
			both = both | (drv === 14'h0003);
		end
		chk("auto cells", 32'(seen), 32'h0003);
		chk("auto alternate", 32'(both), 32'h0);
		chk("auto off", 32'(drv), 32'h0);
		rd(OFF_STATUS);
		chk("auto done", 32'(rv[7]), 32'h1);
		summarize();
	end

	// watchdog well beyond the expected thousand or so cycles
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		summarize();
	end
endmodule
